// ### hw/sct_pkg.sv
package sct_pkg;
  // register addresses
  localparam logic [11:0] ADDR_NOISE_CTRL = 12'h02B;
  localparam logic [11:0] ADDR_PV_DIV = 12'h03D;
  localparam logic [11:0] ADDR_N_DIV = 12'h03E;
  localparam logic [11:0] ADDR_PLL_RESET = 12'h05C;
  localparam logic [11:0] ADDR_VCO_CAL_CTRL = 12'h05D;
  localparam logic [11:0] ADDR_VCO_CAL_STAT = 12'h05E;
  localparam logic [11:0] ADDR_TRIG_CTRL = 12'h100;
  localparam logic [11:0] ADDR_TS_CTRL = 12'h101;
  localparam logic [11:0] ADDR_AUX_CTRL = 12'h102;
  localparam logic [11:0] ADDR_SYSREF_STAT = 12'h103;
  localparam logic [11:0] ADDR_LINK_STAT = 12'h208;
  // reset values
  localparam logic [7:0] RST_NOISE_CTRL = 8'h00;
  localparam logic [7:0] RST_PV_DIV = 8'h32;
  localparam logic [7:0] RST_N_DIV = 8'h0A;
  localparam logic [7:0] RST_PLL_RESET = 8'h01;
  localparam logic [7:0] RST_VCO_CAL_CTRL = 8'h00;
  localparam logic [7:0] RST_TRIG_CTRL = 8'h00;
  localparam logic [7:0] RST_TS_CTRL = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL = 8'h20;
  // field positions
  localparam int P_DIV_LSB = 0;
  localparam int V_DIV_LSB = 4;
  localparam int DIV_W = 4;
  localparam int LOCK_BIT = 4;
  localparam int TRIG_EN_BIT = 0;
  localparam int TRIG_SEL_LSB = 1;
  localparam int RX_DIV_LSB = 4;
  localparam int TS_RECV_BIT = 0;
  localparam int TS_INS_BIT = 1;
  localparam int LINK_MODE_LSB = 2;
  localparam int AUX_OVR_BIT = 0;
  localparam int AUX_C_LSB = 1;
  localparam int AUX_D_LSB = 3;
  localparam int REFOUT_EN_BIT = 5;
  localparam logic [1:0] TRIG_SEL_TIMESTAMP = 2'h3;
  localparam logic [1:0] LINK_MODE_12BIT = 2'h0;
  // supported vco divisor products
  localparam logic [7:0] VP_6 = 8'h06;
  localparam logic [7:0] VP_8 = 8'h08;
  localparam logic [7:0] VP_10 = 8'h0A;
  localparam logic [7:0] VP_12 = 8'h0C;
  localparam logic [7:0] VP_16 = 8'h10;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CAL_TIME_NS = 2000;
  localparam int LOCK_TIME_NS = 1000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_W = 9;
  localparam int WORD_W = 16;

  typedef enum logic [1:0] {
    SCT_PLL_HELD = 2'b00,
    SCT_PLL_CAL = 2'b01,
    SCT_PLL_LOCKING = 2'b10,
    SCT_PLL_LOCKED = 2'b11
  } sct_pll_state_e;

  typedef struct packed {
    logic pll_enable;
    logic ref_select_se;
    logic [1:0] clock_output_straps;
  } sct_straps_s;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [11:0] addr;
    logic [7:0] wdata;
  } sct_reg_req_s;
endpackage

// ### hw/sct_clock_ctrl.sv
//Contract
//- pll strap high selects pll sampling clock
//- reference from single-ended input when selected
//- clock outputs live from reset with pll strap high, power-down kills
//- sampling rate set by v, p, n dividers
//- only divisor products 6,8,10,12,16 lock
//- p,v at 0x3D, n at 0x3E
//- calibration runs when reset cleared with enable
//- done at 0x5E, lock at 0x208
//- noise suppression bits at 0x2B
//- retimed timestamp on trigger when select three
//- timestamp replaces sample lsb when inserting
//- mode 0: data [11:3], timestamp [0]
//- timestamp sampled with the sample, same latency
//- selected clock drives digital and serializer reference
//- divided serializer clock available on trigger
//- sysref captured, setup and hold margin measured
//- pll reference repeated, aux copies when enabled
//- straps set first aux output mode and enable second aux output
`timescale 1ns/1ps

module sct_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      in_ready <= count_next < DEPTH_C;
      out_valid <= count_next != '0;
      // prefetch the head so the data output stays registered
      out_data <= (push && wr_ptr_reg == rd_ptr_next) ? in_data : mem[rd_ptr_next];
    end
  end
endmodule // sct_fifo

module sct_clock_ctrl #(
  parameter int FIFO_DEPTH = 8,
  parameter int CAL_CNT = sct_pkg::CAL_CYCLES,
  parameter int LOCK_CNT = sct_pkg::LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sct_pkg::sct_straps_s straps,
  input wire logic power_down_pin,
  input wire logic diff_clock_input,
  input wire logic single_ended_clock_input,
  input wire logic pll_vco_clock,
  input wire logic serdes_pll_clock,
  input wire logic sysref_in,
  input wire logic timestamp_input,
  input wire sct_pkg::sct_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic sample_in_valid,
  output logic sample_in_ready,
  input wire logic [sct_pkg::SAMPLE_W-1:0] sample_in_data,
  input wire logic sample_in_lsb,
  output logic sample_out_valid,
  input wire logic sample_out_ready,
  output logic [sct_pkg::WORD_W-1:0] sample_out_word,
  output logic sampling_clock,
  output logic serializer_ref_clock,
  output logic reference_clock_output,
  output logic aux_clock_out_c,
  output logic aux_clock_out_d,
  output logic trigger_output,
  output logic va_noise_suppress,
  output logic vclk_noise_suppress
);
  import sct_pkg::*;

  localparam int CW = $clog2((CAL_CNT > LOCK_CNT ? CAL_CNT : LOCK_CNT) + 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CNT - 1);
  localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CNT - 1);

  // ---------------------------------------------------------------
  // straps and registers
  // ---------------------------------------------------------------
  sct_straps_s strap_reg;
  logic [7:0] noise_reg, pv_div_reg, n_div_reg, pll_reset_reg, vco_cal_reg;
  logic [7:0] trig_reg, ts_reg, aux_reg;
  logic [1:0] sysref_flag_reg;
  logic cal_done_reg, lock_reg, bad_div_reg;
  sct_pll_state_e pll_state_reg;
  logic [CW-1:0] pll_cnt_reg;

  // straps are caught while reset is held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_reg <= straps;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      noise_reg <= RST_NOISE_CTRL;
      pv_div_reg <= RST_PV_DIV;
      n_div_reg <= RST_N_DIV;
      pll_reset_reg <= RST_PLL_RESET;
      vco_cal_reg <= RST_VCO_CAL_CTRL;
      trig_reg <= RST_TRIG_CTRL;
      ts_reg <= RST_TS_CTRL;
      aux_reg <= RST_AUX_CTRL;
    end else if (reg_req.wr_en) begin
      unique case (reg_req.addr)
        ADDR_NOISE_CTRL: noise_reg <= reg_req.wdata;
        ADDR_PV_DIV: pv_div_reg <= reg_req.wdata;
        ADDR_N_DIV: n_div_reg <= reg_req.wdata;
        ADDR_PLL_RESET: pll_reset_reg <= {7'h00, reg_req.wdata[0]};
        ADDR_VCO_CAL_CTRL: vco_cal_reg <= {7'h00, reg_req.wdata[0]};
        ADDR_TRIG_CTRL: trig_reg <= reg_req.wdata;
        ADDR_TS_CTRL: ts_reg <= {4'h0, reg_req.wdata[3:0]};
        ADDR_AUX_CTRL: aux_reg <= {2'h0, reg_req.wdata[5:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        unique case (reg_req.addr)
          ADDR_NOISE_CTRL: reg_rdata <= noise_reg;
          ADDR_PV_DIV: reg_rdata <= pv_div_reg;
          ADDR_N_DIV: reg_rdata <= n_div_reg;
          ADDR_PLL_RESET: reg_rdata <= pll_reset_reg;
          ADDR_VCO_CAL_CTRL: reg_rdata <= vco_cal_reg;
          ADDR_VCO_CAL_STAT: reg_rdata <= {6'h00, bad_div_reg, cal_done_reg};
          ADDR_TRIG_CTRL: reg_rdata <= trig_reg;
          ADDR_TS_CTRL: reg_rdata <= ts_reg;
          ADDR_AUX_CTRL: reg_rdata <= aux_reg;
          ADDR_SYSREF_STAT: reg_rdata <= {6'h00, sysref_flag_reg};
          ADDR_LINK_STAT: reg_rdata <= 8'(lock_reg) << LOCK_BIT;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // converter pll sequencing
  // ---------------------------------------------------------------
  logic [7:0] vp_product;
  logic vp_ok;

  assign vp_product = 8'(pv_div_reg[P_DIV_LSB +: DIV_W] * pv_div_reg[V_DIV_LSB +: DIV_W]);
  assign vp_ok = vp_product inside {VP_6, VP_8, VP_10, VP_12, VP_16};

  always_ff @(posedge clk) begin
    if (!rst_n || pll_reset_reg[0] || !strap_reg.pll_enable) begin
      pll_state_reg <= SCT_PLL_HELD;
      pll_cnt_reg <= '0;
      cal_done_reg <= 1'b0;
      lock_reg <= 1'b0;
      bad_div_reg <= 1'b0;
    end else begin
      unique case (pll_state_reg)
        SCT_PLL_HELD: begin
          bad_div_reg <= !vp_ok;
          if (vco_cal_reg[0] && vp_ok) begin
            pll_state_reg <= SCT_PLL_CAL;
          end
        end
        SCT_PLL_CAL: begin
          pll_cnt_reg <= pll_cnt_reg + 1'b1;
          if (pll_cnt_reg == CAL_LAST) begin
            pll_cnt_reg <= '0;
            cal_done_reg <= 1'b1;
            pll_state_reg <= SCT_PLL_LOCKING;
          end
        end
        SCT_PLL_LOCKING: begin
          pll_cnt_reg <= pll_cnt_reg + 1'b1;
          if (pll_cnt_reg == LOCK_LAST) begin
            lock_reg <= 1'b1;
            pll_state_reg <= SCT_PLL_LOCKED;
          end
        end
        SCT_PLL_LOCKED: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock selection and outputs
  // ---------------------------------------------------------------
  logic pll_ref, ref_prev_reg, ref_rise;
  logic [1:0] aux_div_reg;
  logic [1:0] aux_c_mode, aux_d_mode;
  logic outputs_on;

  assign pll_ref = strap_reg.ref_select_se ? single_ended_clock_input : diff_clock_input;
  assign ref_rise = pll_ref && !ref_prev_reg;
  assign outputs_on = strap_reg.pll_enable && !power_down_pin;
  // straps set aux c mode and enable aux d undivided; register modes apply when override set, with aux d held low while aux c mode is 0
  assign aux_c_mode = aux_reg[AUX_OVR_BIT] ? aux_reg[AUX_C_LSB +: 2]
                      : strap_reg.clock_output_straps;
  assign aux_d_mode = aux_reg[AUX_OVR_BIT] ? aux_reg[AUX_D_LSB +: 2]
                      : {1'b0, strap_reg.clock_output_straps != 2'h0};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_prev_reg <= 1'b0;
      aux_div_reg <= 2'h0;
    end else begin
      ref_prev_reg <= pll_ref;
      aux_div_reg <= ref_rise ? aux_div_reg + 1'b1 : aux_div_reg;
    end
  end

  function automatic logic aux_sel(input logic [1:0] mode, input logic ref_lvl,
                                   input logic [1:0] div);
    unique case (mode)
      2'h0: aux_sel = 1'b0;
      2'h1: aux_sel = ref_lvl;
      2'h2: aux_sel = div[0];
      2'h3: aux_sel = div[1];
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampling_clock <= 1'b0;
      serializer_ref_clock <= 1'b0;
      reference_clock_output <= 1'b0;
      aux_clock_out_c <= 1'b0;
      aux_clock_out_d <= 1'b0;
      va_noise_suppress <= 1'b0;
      vclk_noise_suppress <= 1'b0;
    end else begin
      // pll clock only once locked; bypass uses the differential input
      sampling_clock <= strap_reg.pll_enable ? (pll_vco_clock && lock_reg)
                        : diff_clock_input;
      serializer_ref_clock <= strap_reg.pll_enable ? (pll_vco_clock && lock_reg)
                              : diff_clock_input;
      reference_clock_output <= outputs_on && aux_reg[REFOUT_EN_BIT] && pll_ref;
      aux_clock_out_c <= outputs_on && aux_sel(aux_c_mode, pll_ref, aux_div_reg);
      aux_clock_out_d <= outputs_on && aux_c_mode != 2'h0
                         && aux_sel(aux_d_mode, pll_ref, aux_div_reg);
      va_noise_suppress <= noise_reg[0];
      vclk_noise_suppress <= noise_reg[1];
    end
  end

  // ---------------------------------------------------------------
  // sysref capture and margin window
  // ---------------------------------------------------------------
  logic samp_prev_reg, samp_rise, sysref_q_reg, sysref_cap_reg, sysref_chg;
  logic rise_seen_reg;

  assign samp_rise = sampling_clock && !samp_prev_reg;
  assign sysref_chg = sysref_in != sysref_q_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_prev_reg <= 1'b0;
      sysref_q_reg <= 1'b0;
      sysref_cap_reg <= 1'b0;
      rise_seen_reg <= 1'b0;
      sysref_flag_reg <= 2'h0;
    end else begin
      samp_prev_reg <= sampling_clock;
      sysref_q_reg <= sysref_in;
      rise_seen_reg <= samp_rise;
      if (samp_rise) begin
        sysref_cap_reg <= sysref_in;
      end
      // bit0: edge too close before the clock, bit1: too close after
      if (reg_req.rd_en && reg_req.addr == ADDR_SYSREF_STAT) begin
        sysref_flag_reg <= {rise_seen_reg && sysref_chg, samp_rise && sysref_chg};
      end else begin
        sysref_flag_reg <= sysref_flag_reg
                           | {rise_seen_reg && sysref_chg, samp_rise && sysref_chg};
      end
    end
  end

  // ---------------------------------------------------------------
  // timestamp, trigger and sample stream
  // ---------------------------------------------------------------
  logic ts_live, ts_bit, ser_prev_reg, trig_div_reg;
  logic [3:0] ser_cnt_reg;
  logic [WORD_W-1:0] word;

  assign ts_live = ts_reg[TS_RECV_BIT] && timestamp_input;
  // taken in the same cycle as the sample so both share one latency
  assign ts_bit = ts_reg[TS_INS_BIT] ? ts_live : sample_in_lsb;

  always_comb begin
    word = '0;
    if (ts_reg[LINK_MODE_LSB +: 2] == LINK_MODE_12BIT) begin
      word[11:3] = sample_in_data;
      word[0] = ts_bit;
    end else begin
      word[15:7] = sample_in_data;
      word[0] = ts_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ser_prev_reg <= 1'b0;
      ser_cnt_reg <= 4'h0;
      trig_div_reg <= 1'b0;
      trigger_output <= 1'b0;
    end else begin
      ser_prev_reg <= serdes_pll_clock;
      if (serdes_pll_clock && !ser_prev_reg) begin
        ser_cnt_reg <= ser_cnt_reg + 1'b1;
        if (ser_cnt_reg >= trig_reg[RX_DIV_LSB +: 4]) begin
          ser_cnt_reg <= 4'h0;
          trig_div_reg <= !trig_div_reg;
        end
      end
      if (!trig_reg[TRIG_EN_BIT]) begin
        trigger_output <= 1'b0;
      end else if (trig_reg[TRIG_SEL_LSB +: 2] == TRIG_SEL_TIMESTAMP) begin
        trigger_output <= ts_live;
      end else begin
        trigger_output <= trig_div_reg;
      end
    end
  end

  sct_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(sample_in_valid),
    .in_ready(sample_in_ready),
    .in_data(word),
    .out_valid(sample_out_valid),
    .out_ready(sample_out_ready),
    .out_data(sample_out_word)
  );
endmodule // sct_clock_ctrl

// ### test/sct_clock_ctrl_sva.sv
`timescale 1ns/1ps
module sct_clock_ctrl_sva
  import sct_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_down_pin,
  input wire logic timestamp_input,
  input wire sct_pkg::sct_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_in_valid,
  input wire logic sample_in_ready,
  input wire logic [sct_pkg::SAMPLE_W-1:0] sample_in_data,
  input wire logic sample_in_lsb,
  input wire logic sample_out_valid,
  input wire logic [sct_pkg::WORD_W-1:0] sample_out_word,
  input wire logic reference_clock_output,
  input wire logic aux_clock_out_c,
  input wire logic aux_clock_out_d,
  input wire logic trigger_output,
  input wire logic va_noise_suppress
);
  // ----------------------------------------
  // register shadows
  // ----------------------------------------
  logic [7:0] trig_q;
  logic [7:0] ts_q;
  logic held_q;
  logic take;
  assign take = sample_in_valid && sample_in_ready && !sample_out_valid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_q <= RST_TRIG_CTRL;
      ts_q <= RST_TS_CTRL;
      held_q <= 1'b1;
    end else if (reg_req.wr_en) begin
      if (reg_req.addr == ADDR_TRIG_CTRL) trig_q <= reg_req.wdata;
      if (reg_req.addr == ADDR_TS_CTRL) ts_q <= reg_req.wdata;
      if (reg_req.addr == ADDR_PLL_RESET) held_q <= reg_req.wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  noise_bit_a: assert property (
    reg_req.wr_en && reg_req.addr == ADDR_NOISE_CTRL
    |-> ##2 va_noise_suppress == $past(reg_req.wdata[0], 2)) else $error("noise bit wrong");
  power_down_a: assert property (
    power_down_pin [*2] |-> !reference_clock_output && !aux_clock_out_c && !aux_clock_out_d)
    else $error("clock output alive in power down");
  trig_off_a: assert property (!trig_q[0] [*2] |-> !trigger_output)
    else $error("trigger active while disabled");
  trig_stamp_a: assert property (
    (trig_q[0] && trig_q[2:1] == TRIG_SEL_TIMESTAMP && ts_q[0]) [*2]
    |-> trigger_output == $past(timestamp_input)) else $error("trigger not retimed stamp");
  held_done_a: assert property (
    held_q [*3] ##0 (reg_req.rd_en && reg_req.addr == ADDR_VCO_CAL_STAT) |=> !reg_rdata[0])
    else $error("done set while held");
  held_lock_a: assert property (
    held_q [*3] ##0 (reg_req.rd_en && reg_req.addr == ADDR_LINK_STAT) |=> !reg_rdata[LOCK_BIT])
    else $error("lock set while held");
  stamp_word_a: assert property (take && ts_q[1] && ts_q[3:2] == 2'h0 |=>
    sample_out_word[11:3] == $past(sample_in_data)
    && sample_out_word[0] == $past(timestamp_input && ts_q[0])) else $error("mode 0 word wrong");
  plain_lsb_a: assert property (
    take && !ts_q[1] |=> sample_out_word[0] == $past(sample_in_lsb)) else $error("lsb altered");
  wide_word_a: assert property (take && ts_q[1] && ts_q[3:2] != 2'h0 |=>
    sample_out_word[15:7] == $past(sample_in_data)
    && sample_out_word[0] == $past(timestamp_input && ts_q[0])) else $error("wide word wrong");
endmodule // sct_clock_ctrl_sva

bind sct_clock_ctrl sct_clock_ctrl_sva u_sva (.clk, .rst_n, .power_down_pin, .timestamp_input,
  .reg_req, .reg_rdata, .sample_in_valid, .sample_in_ready, .sample_in_data, .sample_in_lsb,
  .sample_out_valid, .sample_out_word, .reference_clock_output, .aux_clock_out_c,
  .aux_clock_out_d, .trigger_output, .va_noise_suppress);

// ### test/sct_sink.sv
`timescale 1ns/1ps
module sct_sink (
  input wire logic clk,
  input wire logic hold,
  input wire logic slow,
  input wire logic valid,
  input wire logic [15:0] word,
  output logic ready
);
  // ----------------------------------------
  // receiving logic: stalls, takes every cycle, or every other cycle when slow
  // ----------------------------------------
  logic [15:0] got[$];
  initial ready = 1'b0;
  always @(posedge clk) begin
    if (valid && ready) got.push_back(word);
    ready <= !hold && (!slow || !ready);
  end
endmodule // sct_sink

// ### test/sct_clock_ctrl_bench.sv
`timescale 1ns/1ps
module sct_clock_ctrl_bench;
  import sct_pkg::*;
  localparam int CAL = 4;
  localparam int LOCK = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sct_straps_s straps = '0;
  logic pd = 1'b0;
  logic ts = 1'b0;
  logic [2:0] ph = 3'h0;
  sct_reg_req_s req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [8:0] in_data = '0;
  logic in_lsb = 1'b0;
  logic out_valid;
  logic out_ready;
  logic [15:0] out_word;
  logic samp_clk;
  logic ref_out;
  logic trig;
  logic va_ns;
  logic vclk_ns;
  logic hold = 1'b1;
  logic slow = 1'b0;
  logic se = 1'b0;
  logic sr = 1'b0;
  logic aux_c;
  logic aux_d;
  logic ser_clk;
  int fails = 0;
  int checks_done = 0;
  int tg[6];
  logic [15:0] expq[$];
  logic [11:0] rv_a[9] = '{12'h02B, 12'h03D, 12'h03E, 12'h05C, 12'h05D, 12'h100, 12'h101,
    12'h102, 12'h300};
  logic [7:0] rv_e[9] = '{8'h00, 8'h32, 8'h0A, 8'h01, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
  logic [7:0] pv[5] = '{8'h32, 8'h42, 8'h52, 8'h62, 8'h44};
  logic [7:0] cfg[3] = '{8'h03, 8'h01, 8'h07};
  always #50 clk = ~clk;
  // slow clock-like inputs
  always @(negedge clk) ph <= ph + 3'h1;
  sct_clock_ctrl #(.FIFO_DEPTH(8), .CAL_CNT(CAL), .LOCK_CNT(LOCK)) dut (.clk, .rst_n, .straps,
    .power_down_pin(pd), .diff_clock_input(ph[1]), .single_ended_clock_input(ph[2]),
    .pll_vco_clock(ph[0]), .serdes_pll_clock(ph[0]), .sysref_in(sr), .timestamp_input(ts),
    .reg_req(req), .reg_rdata(rdata), .reg_rd_valid(rvalid), .sample_in_valid(in_valid),
    .sample_in_ready(in_ready), .sample_in_data(in_data), .sample_in_lsb(in_lsb),
    .sample_out_valid(out_valid), .sample_out_ready(out_ready), .sample_out_word(out_word),
    .sampling_clock(samp_clk), .serializer_ref_clock(ser_clk), .reference_clock_output(ref_out),
    .aux_clock_out_c(aux_c), .aux_clock_out_d(aux_d), .trigger_output(trig),
    .va_noise_suppress(va_ns), .vclk_noise_suppress(vclk_ns));
  sct_sink sink (.clk, .hold, .slow, .valid(out_valid), .word(out_word), .ready(out_ready));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rc(string n, logic [11:0] a, logic [7:0] m, logic [7:0] e);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req = '0;
    chk(n, 16'({rvalid, rdata & m}), 16'({1'b1, e}));
  endtask
  task automatic do_reset(logic pe);
    straps = '{pe, se, 2'b01};
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic watch();
    logic [5:0] prev;
    logic [5:0] cur;
    tg = '{0, 0, 0, 0, 0, 0};
    prev = {ser_clk, aux_d, aux_c, trig, ref_out, samp_clk};
    repeat (40) begin
      @(negedge clk);
      cur = {ser_clk, aux_d, aux_c, trig, ref_out, samp_clk};
      for (int i = 0; i < 6; i++) if (cur[i] !== prev[i]) tg[i]++;
      prev = cur;
    end
  endtask
  task automatic push(logic [8:0] d, logic l, logic t, logic ins, logic [1:0] m);
    logic b;
    @(negedge clk);
    b = ins ? t : l;
    if (in_ready === 1'b1) begin
      in_valid = 1'b1;
      in_data = d;
      in_lsb = l;
      ts = t;
      expq.push_back(m == 2'h0 ? {4'h0, d, 2'h0, b} : {d, 6'h00, b});
      @(negedge clk);
      in_valid = 1'b0;
    end
  endtask
  task automatic drain(logic [15:0] mk);
    hold = 1'b0;
    for (int k = 0; k < 60 && sink.got.size() < expq.size(); k++) @(negedge clk);
    chk("count", 16'(sink.got.size()), 16'(expq.size()));
    foreach (expq[i]) chk("word", sink.got[i] & mk, expq[i] & mk);
    expq.delete();
    sink.got.delete();
    hold = 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #2_000_000;
    fails++;
    report_and_stop();
  end
  initial begin
    do_reset(1'b0);
    watch();
    chk("bypass_clock", 16'(tg[0] > 0), 16'h0001);
    chk("ser_ref", 16'(tg[5] > 0), 16'h0001);
    do_reset(1'b1);
    chk("trig_start", 16'(trig), 16'h0000);
    watch();
    chk("held_clock", 16'(tg[0]), 16'h0000);
    chk("ref_out", 16'(tg[1] > 0), 16'h0001);
    chk("aux_out", 16'({tg[3] > 0, tg[4] > 0}), 16'h0003);
    pd = 1'b1;
    repeat (2) @(negedge clk);
    watch();
    chk("pd_ref", 16'({tg[1] > 0, tg[3] > 0, tg[4] > 0, ref_out}), 16'h0000);
    pd = 1'b0;
    $display("test clocks done");
    foreach (rv_a[i]) rc("reset_val", rv_a[i], 8'hFF, rv_e[i]);
    wr(ADDR_VCO_CAL_STAT, 8'hFF);
    rc("ro_stat", ADDR_VCO_CAL_STAT, 8'hFF, 8'h00);
    wr(ADDR_NOISE_CTRL, 8'h01);
    @(negedge clk);
    chk("noise1", 16'({va_ns, vclk_ns}), 16'h0002);
    wr(ADDR_NOISE_CTRL, 8'h02);
    @(negedge clk);
    chk("noise2", 16'({va_ns, vclk_ns}), 16'h0001);
    $display("test registers done");
    foreach (pv[i]) begin
      wr(ADDR_PLL_RESET, 8'h01);
      rc("held_done", ADDR_VCO_CAL_STAT, 8'h01, 8'h00);
      wr(ADDR_PV_DIV, pv[i]);
      wr(ADDR_N_DIV, 8'h0A);
      wr(ADDR_VCO_CAL_CTRL, 8'h01);
      wr(ADDR_PLL_RESET, 8'h00);
      rc("pv_div", ADDR_PV_DIV, 8'hFF, pv[i]);
      repeat (CAL + LOCK + 4) @(negedge clk);
      rc("cal_done", ADDR_VCO_CAL_STAT, 8'h03, 8'h01);
      rc("locked", ADDR_LINK_STAT, 8'h10, 8'h10);
    end
    watch();
    chk("pll_clock", 16'(tg[0] > 0), 16'h0001);
    sr = 1'b1;
    @(negedge clk);
    sr = 1'b0;
    repeat (2) @(negedge clk);
    rc("sysref_win", ADDR_SYSREF_STAT, 8'h03, 8'h03);
    rc("sysref_clr", ADDR_SYSREF_STAT, 8'h03, 8'h00);
    wr(ADDR_PLL_RESET, 8'h01);
    wr(ADDR_PV_DIV, 8'h33);
    wr(ADDR_PLL_RESET, 8'h00);
    repeat (CAL + LOCK + 4) @(negedge clk);
    rc("bad_div", ADDR_VCO_CAL_STAT, 8'h03, 8'h02);
    rc("bad_lock", ADDR_LINK_STAT, 8'h10, 8'h00);
    $display("test pll done");
    wr(ADDR_TS_CTRL, 8'h01);
    wr(ADDR_TRIG_CTRL, 8'h07);
    ts = 1'b1;
    repeat (3) @(negedge clk);
    chk("trig_hi", 16'(trig), 16'h0001);
    ts = 1'b0;
    repeat (3) @(negedge clk);
    chk("trig_lo", 16'(trig), 16'h0000);
    wr(ADDR_TRIG_CTRL, 8'h11);
    watch();
    chk("trig_clock", 16'(tg[2] > 0), 16'h0001);
    $display("test trigger done");
    foreach (cfg[i]) begin
      wr(ADDR_TS_CTRL, cfg[i]);
      for (int k = 0; k < 12; k++) push(9'(37 * k + 5), k[0], k[1], cfg[i][1], cfg[i][3:2]);
      chk("fill", 16'(expq.size() inside {8, 9}), 16'h0001);
      drain(cfg[i][3:2] == 2'h0 ? 16'h0FF9 : 16'hFF81);
      slow = 1'b1;
    end
    se = 1'b1;
    do_reset(1'b1);
    watch();
    chk("se_ref", 16'(tg[1]), 16'h000A);
    $display("test stream done");
    report_and_stop();
  end
endmodule // sct_clock_ctrl_bench
